// ---- rtl/rtc_params.svh ----
// constants for the nonvolatile timekeeping memory
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH
`define RTC_ADDR_W 15
`define RTC_MEM_DEPTH 32768
`define RTC_REG_BASE 15'h7ff8
`define RTC_OFS_CENT 3'h0
`define RTC_OFS_SEC 3'h1
`define RTC_OFS_MIN 3'h2
`define RTC_OFS_HOUR 3'h3
`define RTC_OFS_DAY 3'h4
`define RTC_OFS_DATE 3'h5
`define RTC_OFS_MONTH 3'h6
`define RTC_OFS_YEAR 3'h7
`define RTC_W_BIT 7
`define RTC_R_BIT 6
`define RTC_STOP_BIT 7
`define RTC_FT_BIT 6
`define RTC_BF_GOOD 1'b1
`define RTC_CLK_HZ 25'd10000000
`define RTC_OSC_HZ 32768
`define RTC_SEC_TICKS 32768
`define RTC_RST_CENT 8'h20
`define RTC_RST_ONE 8'h01
`define RTC_RST_ZERO 8'h00
`define RTC_STROBE_IDLE 3'h7
`define RTC_WB_STAT 3'h0
`define RTC_WB_MASK 3'h4
`define RTC_EV_TICK 0
`define RTC_EV_PFAIL 1
`endif

// ---- rtl/rtc_pkg.sv ----
// types shared by the timekeeping memory
`default_nettype none
package rtc_pkg;
   typedef struct packed {
      logic [7:0] cent;
      logic [7:0] year;
      logic [7:0] month;
      logic [7:0] date;
      logic [7:0] day;
      logic [7:0] hour;
      logic [7:0] min;
      logic [7:0] sec;
   } time_s;
   typedef struct packed {
      logic ce_n;
      logic oe_n;
      logic we_n;
   } strobe_s;
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [2:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } wb_req_s;
endpackage
`default_nettype wire

// ---- rtl/pin_sync.sv ----
// three-stage pin synchroniser with agreement filter
`default_nettype none
module pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic [W-1:0] pin,
   output logic [W-1:0] stable
);
   logic [W-1:0] s1_r, s2_r, s3_r, stable_r, stable_nxt;

   always_comb begin
      stable_nxt = stable_r;
      if (s2_r == s3_r) begin
         stable_nxt = s3_r;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         s1_r <= INIT;
         s2_r <= INIT;
         s3_r <= INIT;
         stable_r <= INIT;
      end else begin
         s1_r <= pin;
         s2_r <= s1_r;
         s3_r <= s2_r;
         stable_r <= stable_nxt;
      end
   end

   assign stable = stable_r;
endmodule // pin_sync
`default_nettype wire

// ---- rtl/bcd_calendar.sv ----
// one-second advance of the bcd time and calendar
`default_nettype none
module bcd_calendar (
   input wire rtc_pkg::time_s cur,
   output rtc_pkg::time_s nxt
);
   import rtc_pkg::*;

   function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] top, input logic [7:0] low);
      if (v >= top) begin
         bcd_inc = low;
      end else if (v[3:0] >= 4'h9) begin
         bcd_inc = {v[7:4] + 4'h1, 4'h0};
      end else begin
         bcd_inc = {v[7:4], v[3:0] + 4'h1};
      end
   endfunction

   function automatic logic [7:0] bcd_bin(input logic [7:0] v);
      bcd_bin = {1'b0, v[7:4], 3'h0} + {3'h0, v[7:4], 1'b0} + {4'h0, v[3:0]};
   endfunction

   logic [7:0] yb, cb, dim;
   logic leap;

   always_comb begin
      yb = bcd_bin(cur.year);
      cb = bcd_bin(cur.cent);
      // century years are leap only when the century divides by four
      leap = (yb[1:0] == 2'h0) && ((yb != 8'h00) || (cb[1:0] == 2'h0)); // see RULE5 see RULE6
      case (cur.month)
         8'h02: begin
            dim = leap ? 8'h29 : 8'h28; // see RULE5
         end
         8'h04, 8'h06, 8'h09, 8'h11: begin
            dim = 8'h30;
         end
         default: begin
            dim = 8'h31;
         end
      endcase
      nxt = cur;
      nxt.sec = bcd_inc(cur.sec, 8'h59, 8'h00); // see RULE4
      if (cur.sec >= 8'h59) begin
         nxt.min = bcd_inc(cur.min, 8'h59, 8'h00);
         if (cur.min >= 8'h59) begin
            nxt.hour = bcd_inc(cur.hour, 8'h23, 8'h00); // see RULE4
            if (cur.hour >= 8'h23) begin
               nxt.day = bcd_inc(cur.day, 8'h07, 8'h01);
               nxt.date = bcd_inc(cur.date, dim, 8'h01);
               if (cur.date >= dim) begin
                  nxt.month = bcd_inc(cur.month, 8'h12, 8'h01);
                  if (cur.month >= 8'h12) begin
                     nxt.year = bcd_inc(cur.year, 8'h99, 8'h00);
                     if (cur.year >= 8'h99) begin
                        nxt.cent = bcd_inc(cur.cent, 8'h39, 8'h00); // see RULE6
                     end
                  end
               end
            end
         end
      end
   end
endmodule // bcd_calendar
`default_nettype wire

// ---- rtl/nv_timekeeping_sram.sv ----
// byte-wide nonvolatile memory with bcd real-time clock in its top eight bytes
// Contract
// RULE1 - 32768 by 8 storage whose contents survive reset
// RULE2 - one byte port: 15-bit address, 8-bit two-way data
// RULE3 - clock registers occupy top eight addresses, accessed like memory
// RULE4 - bcd century to seconds, 24-hour hours
// RULE5 - month lengths and leap february handled automatically through 2100
// RULE6 - century byte extends the two-digit year
// RULE7 - host reads buffered copies, never a half-updated count
// RULE8 - internal counters keep running during host access
// RULE9 - counters advance from a 32.768 kHz countdown chain
// RULE10 - power fail deselects: host reads and writes ignored
// RULE11 - reset output is open drain, active low, pulls low only
// RULE12 - read bit freezes visible copy; refresh within one second after clear
// RULE13 - write bit halts updates; clearing loads values into counters
// RULE14 - seconds msb set stops the oscillator, clear runs it
// RULE15 - reset output held asserted while power fail input active
// RULE16 - strobes synchronised; write completes when the strobe deasserts
`include "rtc_params.svh"
`default_nettype none
module nv_timekeeping_sram #(
   parameter int unsigned OSC_HZ = `RTC_OSC_HZ,
   parameter int unsigned SEC_TICKS = `RTC_SEC_TICKS
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic [14:0] address_bus,
   input wire logic [7:0] data_bus_in,
   output logic [7:0] data_bus_out,
   output logic data_bus_oe,
   input wire rtc_pkg::strobe_s host_strobes,
   input wire logic power_fail,
   output logic reset_n_out,
   output logic reset_n_oe,
   input wire rtc_pkg::wb_req_s wb_req,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq
);
   import rtc_pkg::*;

   function automatic logic is_clock_reg(input logic [14:0] a);
      is_clock_reg = (a >= `RTC_REG_BASE); // see RULE3
   endfunction

   localparam time_s TIME_RST = '{cent: `RTC_RST_CENT, year: `RTC_RST_ZERO, month: `RTC_RST_ONE,
      date: `RTC_RST_ONE, day: `RTC_RST_ONE, hour: `RTC_RST_ZERO, min: `RTC_RST_ZERO, sec: `RTC_RST_ZERO};

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisation
   strobe_s strb;
   logic [14:0] addr_s;
   logic [7:0] data_s;

   pin_sync #(.W(26), .INIT({`RTC_STROBE_IDLE, 15'h0000, 8'h00})) u_sync ( // see RULE16 see RULE2
      .mclk(mclk),
      .reset(reset),
      .pin({host_strobes, address_bus, data_bus_in}),
      .stable({strb, addr_s, data_s})
   );

   ////////////////////////////////////////////////////////////////////////////////
   // oscillator enable and countdown chain
   logic [24:0] acc_r, acc_nxt, acc_sum;
   logic osc_en_r, osc_en_nxt;
   logic [15:0] chain_r, chain_nxt;
   logic sec_tick, stop_r, load;

   always_comb begin
      acc_sum = acc_r + 25'(OSC_HZ);
      acc_nxt = acc_sum;
      osc_en_nxt = 1'b0;
      if (acc_sum >= `RTC_CLK_HZ) begin
         acc_nxt = acc_sum - `RTC_CLK_HZ; // see RULE9
         osc_en_nxt = 1'b1;
      end
      sec_tick = osc_en_r && !stop_r && (chain_r == 16'(SEC_TICKS - 1)); // see RULE9 see RULE14
      chain_nxt = chain_r;
      if (load) begin
         chain_nxt = 16'h0000;
      end else if (osc_en_r && !stop_r) begin
         chain_nxt = sec_tick ? 16'h0000 : chain_r + 16'h0001;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         acc_r <= 25'h0000000;
         osc_en_r <= 1'b0;
         chain_r <= 16'h0000;
      end else begin
         acc_r <= acc_nxt;
         osc_en_r <= osc_en_nxt;
         chain_r <= chain_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // host byte port
   logic wr_active, wr_active_r, wr_commit, rd_sel, mem_we, reg_wr;
   logic [14:0] wr_addr_r, wr_addr_nxt;
   logic [7:0] wr_data_r, wr_data_nxt, dout_r, dout_nxt, reg_rd;
   logic oe_r, oe_nxt, w_r, r_r, ft_r;
   time_s vis_r;
   logic [7:0] mem [0:`RTC_MEM_DEPTH-1];

   always_comb begin
      wr_active = !strb.ce_n && !strb.we_n && !power_fail; // see RULE10
      wr_commit = wr_active_r && !wr_active && !power_fail; // see RULE16 see RULE10
      mem_we = wr_commit && !is_clock_reg(wr_addr_r);
      reg_wr = wr_commit && is_clock_reg(wr_addr_r); // see RULE3
      wr_addr_nxt = wr_active ? addr_s : wr_addr_r;
      wr_data_nxt = wr_active ? data_s : wr_data_r;
      rd_sel = !strb.ce_n && !strb.oe_n && strb.we_n && !power_fail; // see RULE10
      case (addr_s[2:0])
         `RTC_OFS_CENT: reg_rd = {w_r, r_r, vis_r.cent[5:0]};
         `RTC_OFS_SEC: reg_rd = {stop_r, vis_r.sec[6:0]};
         `RTC_OFS_MIN: reg_rd = vis_r.min;
         `RTC_OFS_HOUR: reg_rd = vis_r.hour;
         `RTC_OFS_DAY: reg_rd = {`RTC_BF_GOOD, ft_r, vis_r.day[5:0]};
         `RTC_OFS_DATE: reg_rd = vis_r.date;
         `RTC_OFS_MONTH: reg_rd = vis_r.month;
         default: reg_rd = vis_r.year;
      endcase
      dout_nxt = is_clock_reg(addr_s) ? reg_rd : mem[addr_s]; // see RULE7 see RULE2
      oe_nxt = rd_sel;
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         wr_active_r <= 1'b0;
         wr_addr_r <= 15'h0000;
         wr_data_r <= 8'h00;
         dout_r <= 8'h00;
         oe_r <= 1'b0;
      end else begin
         wr_active_r <= wr_active;
         wr_addr_r <= wr_addr_nxt;
         wr_data_r <= wr_data_nxt;
         dout_r <= dout_nxt;
         oe_r <= oe_nxt;
      end
   end

   // storage has no reset so contents persist
   always_ff @(posedge mclk) begin
      if (mem_we) begin
         mem[wr_addr_r] <= wr_data_r; // see RULE1
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // counters and visible registers
   time_s cnt_r, cnt_nxt, vis_nxt, cal_next;
   logic w_nxt, r_nxt, stop_nxt, ft_nxt;

   bcd_calendar u_cal (
      .cur(cnt_r),
      .nxt(cal_next)
   );

   always_comb begin
      cnt_nxt = cnt_r;
      vis_nxt = vis_r;
      w_nxt = w_r;
      r_nxt = r_r;
      stop_nxt = stop_r;
      ft_nxt = ft_r;
      if (sec_tick) begin
         cnt_nxt = cal_next; // see RULE8
      end
      if (sec_tick && !r_r && !w_r) begin
         vis_nxt = cal_next; // see RULE7 see RULE12
      end
      if (reg_wr) begin
         case (wr_addr_r[2:0])
            `RTC_OFS_CENT: begin
               vis_nxt.cent = {2'h0, wr_data_r[5:0]};
               w_nxt = wr_data_r[`RTC_W_BIT]; // see RULE13
               r_nxt = wr_data_r[`RTC_R_BIT]; // see RULE12
            end
            `RTC_OFS_SEC: begin
               vis_nxt.sec = {1'b0, wr_data_r[6:0]};
               stop_nxt = wr_data_r[`RTC_STOP_BIT]; // see RULE14
            end
            `RTC_OFS_MIN: vis_nxt.min = {1'b0, wr_data_r[6:0]};
            `RTC_OFS_HOUR: vis_nxt.hour = {2'h0, wr_data_r[5:0]};
            `RTC_OFS_DAY: begin
               vis_nxt.day = {5'h00, wr_data_r[2:0]};
               ft_nxt = wr_data_r[`RTC_FT_BIT];
            end
            `RTC_OFS_DATE: vis_nxt.date = {2'h0, wr_data_r[5:0]};
            `RTC_OFS_MONTH: vis_nxt.month = {3'h0, wr_data_r[4:0]};
            default: vis_nxt.year = wr_data_r;
         endcase
      end
      load = w_r && !w_nxt;
      if (load) begin
         cnt_nxt = vis_nxt; // see RULE13
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         cnt_r <= TIME_RST;
         vis_r <= TIME_RST;
         w_r <= 1'b0;
         r_r <= 1'b0;
         stop_r <= 1'b0;
         ft_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         vis_r <= vis_nxt;
         w_r <= w_nxt;
         r_r <= r_nxt;
         stop_r <= stop_nxt;
         ft_r <= ft_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // reset output, wishbone slave and interrupt
   logic rst_oe_r, rst_out_r, pf_d_r, ack_r, ack_nxt, wb_hit, irq_r, irq_nxt;
   logic [1:0] status_r, status_nxt, mask_r, mask_nxt, ev;
   logic [31:0] wbd_r, wbd_nxt;

   always_comb begin
      wb_hit = wb_req.cyc && wb_req.stb && !ack_r;
      ack_nxt = wb_hit;
      ev = 2'h0;
      ev[`RTC_EV_TICK] = sec_tick;
      ev[`RTC_EV_PFAIL] = power_fail && !pf_d_r;
      status_nxt = status_r;
      mask_nxt = mask_r;
      wbd_nxt = wbd_r;
      if (wb_hit) begin
         case (wb_req.adr)
            `RTC_WB_STAT: wbd_nxt = {30'h00000000, status_r};
            `RTC_WB_MASK: wbd_nxt = {30'h00000000, mask_r};
            default: wbd_nxt = 32'h00000000;
         endcase
         if (wb_req.we && wb_req.sel[0] && (wb_req.adr == `RTC_WB_STAT)) begin
            status_nxt = status_r & ~wb_req.dat[1:0];
         end
         if (wb_req.we && wb_req.sel[0] && (wb_req.adr == `RTC_WB_MASK)) begin
            mask_nxt = wb_req.dat[1:0];
         end
      end
      status_nxt = status_nxt | ev;
      irq_nxt = |(status_r & mask_r);
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         rst_oe_r <= 1'b1;
         rst_out_r <= 1'b0;
         pf_d_r <= 1'b0;
         ack_r <= 1'b0;
         wbd_r <= 32'h00000000;
         status_r <= 2'h0;
         mask_r <= 2'h0;
         irq_r <= 1'b0;
      end else begin
         rst_oe_r <= power_fail; // see RULE15 see RULE11
         rst_out_r <= 1'b0; // see RULE11
         pf_d_r <= power_fail;
         ack_r <= ack_nxt;
         wbd_r <= wbd_nxt;
         status_r <= status_nxt;
         mask_r <= mask_nxt;
         irq_r <= irq_nxt;
      end
   end

   assign data_bus_out = dout_r;
   assign data_bus_oe = oe_r;
   assign reset_n_out = rst_out_r;
   assign reset_n_oe = rst_oe_r;
   assign wb_dat_o = wbd_r;
   assign wb_ack_o = ack_r;
   assign irq = irq_r;

   ////////////////////////////////////////////////////////////////////////////////
   // assertions
   AST_PF_NO_DRIVE: assert property (power_fail |=> !oe_r) // see RULE10
      else $error("data bus driven during power fail");
   AST_PF_NO_WRITE: assert property (power_fail |-> !mem_we && !reg_wr) // see RULE10
      else $error("write accepted during power fail");
   AST_RST_LOW_ONLY: assert property (rst_out_r == 1'b0) // see RULE11
      else $error("reset output drives high");
   AST_RST_HELD: assert property (power_fail ##1 power_fail |=> rst_oe_r ##0 $past(rst_oe_r)) // see RULE15
      else $error("reset output released during power fail");
   AST_MEM_WRITE: assert property (mem_we |=> mem[$past(wr_addr_r)] == $past(wr_data_r)) // see RULE1
      else $error("memory byte not stored");
   AST_WRITE_ON_RELEASE: assert property (mem_we |-> $past(wr_active) && !wr_active) // see RULE16
      else $error("write completed while strobe still low");
   AST_FREEZE: assert property (r_r && !reg_wr |=> vis_r == $past(vis_r)) // see RULE12
      else $error("visible time changed while frozen");
   AST_LOAD: assert property ($fell(w_r) |-> cnt_r == $past(vis_nxt)) // see RULE13
      else $error("counters not loaded on write bit clear");
   AST_STOPPED: assert property (stop_r && !load |=> cnt_r == $past(cnt_r)) // see RULE14
      else $error("time advanced with oscillator stopped");
   AST_ADVANCE: assert property (sec_tick && !load |=> cnt_r == $past(cal_next)) // see RULE8 see RULE9
      else $error("counter missed a second");
   AST_BCD_RANGE: assert property (cnt_r.hour <= 8'h23 && cnt_r.sec <= 8'h59 && cnt_r.min <= 8'h59) // see RULE4
      else $error("time field out of bcd range");
   AST_FEB: assert property (cnt_r.month == 8'h02 && !load |-> cnt_r.date <= 8'h29) // see RULE5
      else $error("february date out of range");
   COV_FREEZE: cover property (r_r && sec_tick);
   COV_LOAD: cover property ($fell(w_r));
   COV_LEAP: cover property (cnt_r.month == 8'h02 && cnt_r.date == 8'h29);
   COV_PF: cover property (power_fail && wr_active_r);
endmodule // nv_timekeeping_sram
`default_nettype wire

// ---- test/host_bus_model.sv ----
// host side of the byte bus: strobes, address and the shared data wire
`default_nettype none
module host_bus_model (
   input wire logic mclk,
   input wire logic [7:0] dev_dat,
   input wire logic dev_oe,
   output logic [14:0] address_bus,
   output logic [7:0] data_bus_in,
   output rtc_pkg::strobe_s host_strobes
);
   timeunit 1ns;
   timeprecision 1ns;
   import rtc_pkg::*;
   logic drv_r = 1'b0;
   logic [7:0] dat_r = 8'h00;
   logic [7:0] last_r = 8'h00;
   int miss_count = 0;
   // undriven wire shows the inverse of its last driven level
   assign data_bus_in = dev_oe ? dev_dat : (drv_r ? dat_r : ~last_r);
   always @(posedge mclk) begin
      if (dev_oe === 1'b1 || drv_r) begin
         last_r <= data_bus_in;
      end
   end
   initial begin
      address_bus = 15'h0000;
      host_strobes = 3'h7;
   end
   task automatic write_byte(input logic [14:0] a, input logic [7:0] d);
      @(posedge mclk);
      address_bus <= a;
      dat_r <= d;
      drv_r <= 1'b1;
      host_strobes <= 3'h2;
      repeat (4) @(posedge mclk);
      host_strobes <= 3'h7;
      repeat (6) @(posedge mclk);
      drv_r <= 1'b0;
   endtask
   task automatic read_byte(input logic [14:0] a, output logic [7:0] d);
      int n;
      @(posedge mclk);
      address_bus <= a;
      host_strobes <= 3'h1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (dev_oe !== 1'b1 && n < 20);
      if (dev_oe !== 1'b1) begin
         miss_count++;
      end
      repeat (2) @(posedge mclk);
      d = data_bus_in;
      host_strobes <= 3'h7;
      repeat (6) @(posedge mclk);
   endtask
endmodule // host_bus_model
`default_nettype wire

// ---- test/nv_timekeeping_sram_tb.sv ----
// self-checking bench for the timekeeping memory
`include "rtc_params.svh"
`default_nettype none
module nv_timekeeping_sram_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import rtc_pkg::*;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic power_fail = 1'b0;
   logic [14:0] address_bus;
   logic [7:0] data_bus_in, data_bus_out;
   logic data_bus_oe, reset_n_out, reset_n_oe, wb_ack_o, irq;
   strobe_s host_strobes;
   wb_req_s wb_req = '0;
   logic [31:0] wb_dat_o;
   wire logic rst_line;
   int bad_count = 0;
   int checked = 0;
   int pf_oe = 0;
   assign rst_line = reset_n_oe ? reset_n_out : 1'b1;
   nv_timekeeping_sram #(.OSC_HZ(1000000), .SEC_TICKS(4)) i_nv_timekeeping_sram (
      .mclk(mclk), .reset(reset), .address_bus(address_bus), .data_bus_in(data_bus_in),
      .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe), .host_strobes(host_strobes),
      .power_fail(power_fail), .reset_n_out(reset_n_out), .reset_n_oe(reset_n_oe),
      .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq));
   host_bus_model i_host_bus_model (.mclk(mclk), .dev_dat(data_bus_out), .dev_oe(data_bus_oe),
      .address_bus(address_bus), .data_bus_in(data_bus_in), .host_strobes(host_strobes));
   always @(posedge mclk) begin
      if (power_fail === 1'b1 && data_bus_oe !== 1'b0) pf_oe++;
   end
   ////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic wb(input logic wr, input logic [2:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge mclk);
      wb_req <= '{cyc:1'b1, stb:1'b1, we:wr, adr:a, sel:4'h1, dat:d};
      do begin
         @(posedge mclk);
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_req <= '0;
      @(posedge mclk);
   endtask
   task automatic load_time(input time_s t);
      i_host_bus_model.write_byte(`RTC_REG_BASE, t.cent | 8'h80);
      for (int k = 1; k < 8; k++) begin
         i_host_bus_model.write_byte(`RTC_REG_BASE + 15'(k), t[8*(k-1) +: 8]);
      end
      i_host_bus_model.write_byte(`RTC_REG_BASE, t.cent);
   endtask
   task automatic read_time(output time_s t);
      for (int k = 0; k < 8; k++) begin
         i_host_bus_model.read_byte(`RTC_REG_BASE + 15'(k), t[8*((k+7)%8) +: 8]);
      end
   endtask
   ////////////////////////////////////////
   task automatic t_mem();
      logic [7:0] q;
      i_host_bus_model.write_byte(15'h0123, 8'h5a);
      i_host_bus_model.write_byte(15'h7ff7, 8'ha5);
      i_host_bus_model.read_byte(15'h0123, q);
      check(32'(q), 32'h5a, "low byte");
      i_host_bus_model.read_byte(15'h7ff7, q);
      check(32'(q), 32'ha5, "byte below clock");
      $display("test memory done");
   endtask
   task automatic t_reset_vals();
      time_s t;
      read_time(t);
      check(32'(t[63:32]), 32'h20000101, "cent year month date");
      check(32'(t.day), 32'h81, "day with flag");
      $display("test reset values done");
   endtask
   task automatic t_calendar();
      time_s t;
      logic [7:0] cents [2] = '{8'h20, 8'h21};
      logic [15:0] md [2] = '{16'h0229, 16'h0301};
      for (int i = 0; i < 2; i++) begin
         load_time({cents[i], 8'h00, 8'h02, 8'h28, 8'h02, 8'h23, 8'h59, 8'h59});
         repeat (45) @(posedge mclk);
         i_host_bus_model.write_byte(`RTC_REG_BASE, cents[i] | 8'h40);
         read_time(t);
         check(32'(t[55:40]), {16'h0, 8'h00, md[i][15:8]}, "year month");
         check(32'(t.date), 32'(md[i][7:0]), "date");
         check(t[31:0], 32'h83000000, "day hour min sec");
         i_host_bus_model.write_byte(`RTC_REG_BASE, cents[i]);
      end
      $display("test calendar done");
   endtask
   task automatic t_freeze();
      logic [7:0] s0, s1;
      i_host_bus_model.write_byte(`RTC_REG_BASE, 8'h61);
      i_host_bus_model.read_byte(`RTC_REG_BASE + 15'h1, s0);
      repeat (200) @(posedge mclk);
      i_host_bus_model.read_byte(`RTC_REG_BASE + 15'h1, s1);
      check(32'(s1), 32'(s0), "frozen seconds");
      i_host_bus_model.write_byte(`RTC_REG_BASE, 8'h21);
      repeat (50) @(posedge mclk);
      i_host_bus_model.write_byte(`RTC_REG_BASE, 8'h61);
      i_host_bus_model.read_byte(`RTC_REG_BASE + 15'h1, s1);
      check(32'(s1 >= s0 + 8'h05), 32'h1, "seconds kept counting");
      i_host_bus_model.write_byte(`RTC_REG_BASE, 8'h21);
      $display("test freeze done");
   endtask
   task automatic t_wb();
      logic [31:0] q;
      wb(1'b1, `RTC_WB_MASK, 32'h0, q);
      wb(1'b1, `RTC_WB_STAT, 32'h3, q);
      wb(1'b1, `RTC_WB_MASK, 32'h2, q);
      repeat (2) @(posedge mclk);
      check(32'(irq), 32'h0, "irq idle");
      @(posedge mclk) power_fail <= 1'b1;
      repeat (3) @(posedge mclk) power_fail <= 1'b0;
      repeat (6) @(posedge mclk);
      check(32'(irq), 32'h1, "irq raised");
      wb(1'b0, `RTC_WB_STAT, 32'h0, q);
      check(32'(q[1]), 32'h1, "fail event");
      wb(1'b1, `RTC_WB_STAT, 32'h2, q);
      repeat (3) @(posedge mclk);
      check(32'(irq), 32'h0, "irq cleared");
      wb(1'b1, `RTC_WB_MASK, 32'h1, q);
      repeat (60) @(posedge mclk);
      check(32'(irq), 32'h1, "tick irq");
      wb(1'b0, `RTC_WB_MASK, 32'h0, q);
      check(q, 32'h1, "mask readback");
      wb(1'b1, `RTC_WB_MASK, 32'h0, q);
      wb(1'b1, 3'h2, 32'hff, q);
      wb(1'b0, 3'h2, 32'h0, q);
      check(q, 32'h0, "unmapped");
      repeat (3) @(posedge mclk);
      check(32'(irq), 32'h0, "irq masked");
      $display("test interrupts done");
   endtask
   task automatic t_pfail();
      logic [7:0] q;
      i_host_bus_model.write_byte(15'h0040, 8'h3c);
      @(posedge mclk) power_fail <= 1'b1;
      repeat (3) @(posedge mclk);
      check(32'(rst_line), 32'h0, "reset line low");
      check(32'(reset_n_out), 32'h0, "drain only");
      i_host_bus_model.write_byte(15'h0040, 8'hc3);
      i_host_bus_model.read_byte(15'h0040, q);
      check(32'(pf_oe), 32'h0, "no drive in fail");
      check(32'(i_host_bus_model.miss_count), 32'h1, "read refused in fail");
      @(posedge mclk) power_fail <= 1'b0;
      repeat (4) @(posedge mclk);
      check(32'(rst_line), 32'h1, "reset line released");
      i_host_bus_model.read_byte(15'h0040, q);
      check(32'(q), 32'h3c, "byte kept");
      $display("test power fail done");
   endtask
   task automatic t_stop();
      logic [7:0] q;
      load_time({8'h20, 8'h01, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h80});
      repeat (100) @(posedge mclk);
      i_host_bus_model.write_byte(`RTC_REG_BASE, 8'h60);
      i_host_bus_model.read_byte(`RTC_REG_BASE + 15'h1, q);
      check(32'(q), 32'h80, "stopped seconds");
      i_host_bus_model.write_byte(`RTC_REG_BASE + 15'h4, 8'h45);
      i_host_bus_model.read_byte(`RTC_REG_BASE + 15'h4, q);
      check(32'(q), 32'hc5, "day with test bit");
      $display("test stop done");
   endtask
   ////////////////////////////////////////
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      forever #50 mclk = ~mclk;
   end
   initial begin
      repeat (5) @(posedge mclk);
      reset <= 1'b0;
      repeat (4) @(posedge mclk);
      t_mem();
      t_reset_vals();
      t_calendar();
      t_freeze();
      t_wb();
      t_pfail();
      t_stop();
      check(32'(i_host_bus_model.miss_count), 32'h1, "unanswered reads");
      stop_test();
   end
   initial begin
      #2000000;
      bad_count++;
      $display("mismatch at %0t: watchdog expired", $time);
      stop_test();
   end
endmodule // nv_timekeeping_sram_tb
`default_nettype wire
